// file: core/rts_pkg.sv
`default_nettype none
// Shared constants for the reset and time-out sequencer
package rts_pkg;

   // Main clock
   localparam int CLK_PERIOD_NS     = 25;

   // Supply-dip minimum duration, least time, rounded up to whole cycles
   localparam int DIP_MIN_NS        = 100000;
   localparam int DIP_MIN_CYC       = (DIP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Glitch filter on the external reset pin, least time
   localparam int EXT_FILTER_NS     = 250;
   localparam int EXT_FILTER_CYC    = (EXT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Power-up delay, counted in slow RC ticks
   localparam int POWERUP_DELAY_TIMER_DELAY_US     = 72000;
   localparam int RC_TICK_PERIOD_US = 18;
   localparam int POWERUP_DELAY_TIMER_TICKS        = POWERUP_DELAY_TIMER_DELAY_US / RC_TICK_PERIOD_US;

   // Oscillator settle count
   localparam int OST_CYCLES        = 1024;

   // Oscillator mode encoding
   typedef enum logic [1:0] {
      OSC_LP = 2'b00,
      OSC_XT = 2'b01,
      OSC_HS = 2'b10,
      OSC_RC = 2'b11
   } rts_osc_t;

   // Sequencer states, Gray coded along the cold path
   typedef enum logic [2:0] {
      ST_HOLD  = 3'b000,
      ST_POWERUP_DELAY_TIMER  = 3'b001,
      ST_OST   = 3'b011,
      ST_EXT   = 3'b010,
      ST_RUN   = 3'b110,
      ST_SLEEP = 3'b111
   } rts_state_t;

   // Register map
   localparam int         ADDR_W      = 3;
   localparam logic [2:0] ADDR_PRS    = 3'h0;
   localparam logic [2:0] ADDR_STATUS = 3'h1;
   localparam logic [2:0] ADDR_OPTION = 3'h2;
   localparam logic [2:0] ADDR_DIR    = 3'h3;
   localparam logic [2:0] ADDR_CFG    = 3'h4;
   localparam logic [2:0] ADDR_SEQ    = 3'h5;

   // Field positions
   localparam int PRS_DIP_BIT  = 0;
   localparam int PRS_POR_BIT  = 1;
   localparam int ST_TO_BIT    = 4;
   localparam int ST_PD_BIT    = 3;
   localparam int ST_BANK_LSB  = 5;
   localparam int CFG_PDC_BIT  = 2;
   localparam int CFG_DIP_BIT  = 3;

   // Reset values and write masks
   localparam logic [7:0] PRS_RST      = 8'h00;
   localparam logic [7:0] PRS_MASK     = 8'h03;
   localparam logic [7:0] STATUS_POR   = 8'h18;
   localparam logic [7:0] STATUS_SWMSK = 8'he7;
   localparam logic [7:0] OPTION_RST   = 8'hff;
   localparam logic [7:0] DIR_RST      = 8'hff;
   localparam logic [7:0] CFG_RST      = 8'h09;
   localparam logic [7:0] CFG_MASK     = 8'h0f;

   // Program counter
   localparam int          PC_W       = 13;
   localparam logic [12:0] PC_RESET   = 13'h0000;
   localparam logic [12:0] PC_IRQ_VEC = 13'h0004;
   localparam logic [12:0] PC_STEP    = 13'h0001;

endpackage
`default_nettype wire

// file: core/rts_event_filter.sv
`default_nettype none
// Synchronises a level and passes its assertion only after HOLD_CYC + 1
// steady cycles; release follows the synchronised level at once.
module rts_event_filter #(
   parameter int unsigned HOLD_CYC = 10
) (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_n_i,
   // Raw level, active high, from outside the clock domain
   input  wire logic event_raw_i,
   // Filtered level
   output logic      event_o
);

   localparam int             CW      = $clog2(HOLD_CYC + 1);
   localparam logic [CW-1:0]  CNT_MAX = CW'(HOLD_CYC);

   logic          sync1_reg;
   logic          sync2_reg;
   logic [CW-1:0] cnt_reg;
   logic          event_reg;

   // Two-flop synchroniser
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= event_raw_i;
         sync2_reg <= sync1_reg;
      end
   end

   // Steady-level counter; short pulses never reach the terminal count
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cnt_reg   <= '0;
         event_reg <= 1'b0;
      end
      else if (!sync2_reg)
      begin
         cnt_reg   <= '0;
         event_reg <= 1'b0;
      end
      else if (cnt_reg != CNT_MAX)
      begin
         cnt_reg   <= cnt_reg + 1'b1;
      end
      else
      begin
         event_reg <= 1'b1;
      end
   end

   assign event_o = event_reg;

endmodule
`default_nettype wire

// file: core/rts_sequencer.sv
`default_nettype none
module rts_sequencer
   import rts_pkg::*;
#(
   parameter int unsigned POWERUP_DELAY_TIMER_TICKS_P     = rts_pkg::POWERUP_DELAY_TIMER_TICKS,
   parameter int unsigned OST_CYCLES_P     = rts_pkg::OST_CYCLES,
   parameter int unsigned DIP_MIN_CYC_P    = rts_pkg::DIP_MIN_CYC,
   parameter int unsigned EXT_FILTER_CYC_P = rts_pkg::EXT_FILTER_CYC
) (
   // Clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    reset_n_i,
   // Supply, pin and oscillator inputs
   input  wire logic                    power_rise_i,
   input  wire logic                    supply_dip_i,
   input  wire logic                    external_reset_n_i,
   input  wire logic                    rc_tick_i,
   input  wire logic                    osc_clk_i,
   // Core events
   input  wire logic                    watchdog_timeout_i,
   input  wire logic                    sleep_enter_i,
   input  wire logic                    irq_wake_i,
   input  wire logic                    global_irq_enable_i,
   input  wire logic [rts_pkg::PC_W-1:0] pc_i,
   // Reset and core control
   output logic                         device_reset_n_o,
   output logic                         core_stall_o,
   output logic                         pc_load_o,
   output logic [rts_pkg::PC_W-1:0]     pc_load_value_o,
   output logic [7:0]                   status_o,
   output logic [7:0]                   option_o,
   output logic [7:0]                   direction_o,
   // Register port
   input  wire logic [rts_pkg::ADDR_W-1:0] reg_addr_i,
   input  wire logic [7:0]              reg_wdata_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   output logic [7:0]                   reg_rdata_o
);

   localparam int PTW = $clog2(POWERUP_DELAY_TIMER_TICKS_P + 1);
   localparam int OCW = $clog2(OST_CYCLES_P + 1);

   // True when a counter sits on its final step
   function automatic logic at_last(input int unsigned cnt, input int unsigned total);
      at_last = (cnt == total - 1);
   endfunction

   rts_state_t      state_reg;
   rts_state_t      state_next;
   logic [PTW-1:0]  powerup_delay_timer_cnt_reg;
   logic [OCW-1:0]  ost_cnt_reg;
   logic            wake_reg;
   logic            wake_vec_reg;
   logic            por_q1_reg;
   logic            por_q2_reg;
   logic [2:0]      tick_sync_reg;
   logic [2:0]      osc_sync_reg;
   logic [7:0]      prs_reg;
   logic [7:0]      prs_next;
   logic [7:0]      status_reg;
   logic [7:0]      status_next;
   logic [7:0]      option_reg;
   logic [7:0]      dir_reg;
   logic [7:0]      cfg_reg;
   logic            pc_load_reg;
   logic [PC_W-1:0] pc_val_reg;
   logic [7:0]      rdata_reg;

   wire logic       dip_long;
   wire logic       ext_low;
   wire logic       por_cause_n;

   // Filtered supply dip and filtered external reset pin
   rts_event_filter #(
      .HOLD_CYC (DIP_MIN_CYC_P)
   ) u_dip_filter (
      .mclk_i      (mclk_i),
      .reset_n_i   (reset_n_i),
      .event_raw_i (supply_dip_i),
      .event_o     (dip_long)
   );

   rts_event_filter #(
      .HOLD_CYC (EXT_FILTER_CYC_P)
   ) u_ext_filter (
      .mclk_i      (mclk_i),
      .reset_n_i   (reset_n_i),
      .event_raw_i (~external_reset_n_i),
      .event_o     (ext_low)
   );

   // Power rise asserts at once and releases two edges after the pulse
   assign por_cause_n = reset_n_i & ~power_rise_i;

   always_ff @(posedge mclk_i or negedge por_cause_n)
   begin
      if (!por_cause_n)
      begin
         por_q1_reg <= 1'b1;
         por_q2_reg <= 1'b1;
      end
      else
      begin
         por_q1_reg <= 1'b0;
         por_q2_reg <= por_q1_reg;
      end
   end

   // Tick and oscillator synchronisers with a third stage for edges
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         tick_sync_reg <= 3'h0;
         osc_sync_reg  <= 3'h0;
      end
      else
      begin
         tick_sync_reg <= {tick_sync_reg[1:0], rc_tick_i};
         osc_sync_reg  <= {osc_sync_reg[1:0], osc_clk_i};
      end
   end

   // Configuration decode
   wire logic cfg_pdc     = cfg_reg[CFG_PDC_BIT];
   wire logic cfg_dip     = cfg_reg[CFG_DIP_BIT];
   wire logic crystal     = (rts_osc_t'(cfg_reg[1:0]) != OSC_RC);
   wire logic use_powerup_delay_timer    = ~cfg_pdc | cfg_dip;
   wire logic dip_rst     = cfg_dip & dip_long;
   wire logic tick_edge   = tick_sync_reg[1] & ~tick_sync_reg[2];
   wire logic osc_edge    = osc_sync_reg[1] & ~osc_sync_reg[2];
   wire logic powerup_delay_timer_done   = tick_edge & at_last(32'(powerup_delay_timer_cnt_reg), POWERUP_DELAY_TIMER_TICKS_P);
   wire logic ost_done    = osc_edge & at_last(32'(ost_cnt_reg), OST_CYCLES_P);

   // Cause events, highest priority first
   wire logic ev_por      = por_q2_reg;
   wire logic ev_dip      = dip_rst & ~ev_por;
   wire logic cold        = ev_por | ev_dip;
   wire logic in_sleep    = (state_reg == ST_SLEEP);
   wire logic in_run      = (state_reg == ST_RUN);
   wire logic ev_ext      = ext_low & ~cold & ~in_sleep;
   wire logic ev_ext_slp  = ext_low & ~cold & in_sleep;
   wire logic ev_wdt_rst  = watchdog_timeout_i & in_run & ~cold & ~ext_low;
   wire logic ev_wdt_wake = watchdog_timeout_i & in_sleep & ~cold & ~ext_low;
   wire logic ev_irq_wake = irq_wake_i & in_sleep & ~cold & ~ext_low & ~watchdog_timeout_i;
   wire logic ev_sleep    = sleep_enter_i & in_run & ~cold & ~ext_low & ~watchdog_timeout_i;
   wire logic any_reset   = cold | ev_ext | ev_ext_slp | ev_wdt_rst;
   wire logic enter_run   = (state_next == ST_RUN) & ~in_run;

   // Sequencer next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_HOLD:
            if (use_powerup_delay_timer)
               state_next = ST_POWERUP_DELAY_TIMER;
            else if (crystal)
               state_next = ST_OST;
            else
               state_next = ST_EXT;
         ST_POWERUP_DELAY_TIMER:
            if (powerup_delay_timer_done)
               state_next = crystal ? ST_OST : ST_EXT;
         ST_OST:
            if (ost_done)
               state_next = wake_reg ? ST_RUN : ST_EXT;
         ST_EXT:
            if (!ext_low)
               state_next = ST_RUN;
         ST_RUN:
            if (ev_wdt_rst)
               state_next = ST_EXT;
            else if (ev_sleep)
               state_next = ST_SLEEP;
         ST_SLEEP:
            if (ev_wdt_wake || ev_irq_wake)
               state_next = crystal ? ST_OST : ST_RUN;
         default:
            state_next = ST_HOLD;
      endcase
      if (cold)
         state_next = ST_HOLD;
      else if (ext_low && (in_run || in_sleep))
         state_next = ST_EXT;
   end

   // State, stage counters and wake bookkeeping
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_reg    <= ST_HOLD;
         powerup_delay_timer_cnt_reg <= '0;
         ost_cnt_reg  <= '0;
         wake_reg     <= 1'b0;
         wake_vec_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (state_reg != ST_POWERUP_DELAY_TIMER)
            powerup_delay_timer_cnt_reg <= '0;
         else if (tick_edge)
            powerup_delay_timer_cnt_reg <= powerup_delay_timer_cnt_reg + 1'b1;
         if (state_reg != ST_OST)
            ost_cnt_reg <= '0;
         else if (osc_edge)
            ost_cnt_reg <= ost_cnt_reg + 1'b1;
         if (ev_wdt_wake || ev_irq_wake)
         begin
            wake_reg     <= 1'b1;
            wake_vec_reg <= ev_irq_wake & global_irq_enable_i;
         end
         else if (any_reset)
         begin
            wake_reg     <= 1'b0;
            wake_vec_reg <= 1'b0;
         end
      end
   end

   // Program counter load on each return to running
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pc_load_reg <= 1'b0;
         pc_val_reg  <= PC_RESET;
      end
      else
      begin
         pc_load_reg <= enter_run;
         if (enter_run && !wake_reg)
            pc_val_reg <= PC_RESET;
         else if (enter_run && wake_vec_reg)
            pc_val_reg <= PC_IRQ_VEC;
         else if (enter_run)
            pc_val_reg <= pc_i + PC_STEP;
      end
   end

   // Register port decode
   wire logic wr_prs    = reg_wr_i & (reg_addr_i == ADDR_PRS);
   wire logic wr_status = reg_wr_i & (reg_addr_i == ADDR_STATUS);
   wire logic wr_option = reg_wr_i & (reg_addr_i == ADDR_OPTION);
   wire logic wr_dir    = reg_wr_i & (reg_addr_i == ADDR_DIR);
   wire logic wr_cfg    = reg_wr_i & (reg_addr_i == ADDR_CFG);

   // Power status bits: software sets, a cause clears and wins
   always_comb
   begin
      prs_next = prs_reg;
      if (wr_prs)
         prs_next = reg_wdata_i & PRS_MASK;
      if (ev_por)
         prs_next[PRS_POR_BIT] = 1'b0;
      if (ev_dip)
         prs_next[PRS_DIP_BIT] = 1'b0;
   end

   // Status register: bank bits, flags and low bits per cause
   always_comb
   begin
      status_next = status_reg;
      if (wr_status)
         status_next = (reg_wdata_i & STATUS_SWMSK) | (status_reg & ~STATUS_SWMSK);
      if (ev_por)
         status_next = STATUS_POR;
      else if (ev_dip)
         status_next = {3'b000, 1'b1, 1'b1, status_reg[2:0]};
      else if (ev_ext_slp)
         status_next = {3'b000, 1'b1, 1'b0, status_reg[2:0]};
      else if (ev_ext)
         status_next[7:ST_BANK_LSB] = 3'b000;
      else if (ev_wdt_rst)
         status_next = {3'b000, 1'b0, 1'b1, status_reg[2:0]};
      else if (ev_wdt_wake)
      begin
         status_next[ST_TO_BIT] = 1'b0;
         status_next[ST_PD_BIT] = 1'b0;
      end
      else if (ev_irq_wake || ev_sleep)
      begin
         status_next[ST_TO_BIT] = 1'b1;
         status_next[ST_PD_BIT] = 1'b0;
      end
   end

   // Register storage
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         prs_reg    <= PRS_RST;
         status_reg <= STATUS_POR;
         option_reg <= OPTION_RST;
         dir_reg    <= DIR_RST;
         cfg_reg    <= CFG_RST;
      end
      else
      begin
         prs_reg    <= prs_next;
         status_reg <= status_next;
         if (any_reset)
         begin
            option_reg <= OPTION_RST;
            dir_reg    <= DIR_RST;
         end
         else
         begin
            if (wr_option)
               option_reg <= reg_wdata_i;
            if (wr_dir)
               dir_reg <= reg_wdata_i;
         end
         if (wr_cfg)
            cfg_reg <= reg_wdata_i & CFG_MASK;
      end
   end

   // Read mux; unmapped addresses read zero
   wire logic [7:0] rd_mux =
      (reg_addr_i == ADDR_PRS)    ? prs_reg    :
      (reg_addr_i == ADDR_STATUS) ? status_reg :
      (reg_addr_i == ADDR_OPTION) ? option_reg :
      (reg_addr_i == ADDR_DIR)    ? dir_reg    :
      (reg_addr_i == ADDR_CFG)    ? cfg_reg    :
      (reg_addr_i == ADDR_SEQ)    ? {5'h00, state_reg} : 8'h00;

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge mclk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= reg_rd_i ? rd_mux : 8'h00;
   end

   // Internal reset: immediate on power, dip and pin causes, a cycle later on watchdog, held through cold stages
   wire logic cold_stage = (state_reg == ST_HOLD) || (state_reg == ST_POWERUP_DELAY_TIMER) ||
                           (state_reg == ST_EXT) || ((state_reg == ST_OST) && !wake_reg);

   assign device_reset_n_o = ~(por_q2_reg | dip_rst | ext_low | cold_stage);
   assign core_stall_o     = ~in_run | ~device_reset_n_o;
   assign pc_load_o        = pc_load_reg;
   assign pc_load_value_o  = pc_val_reg;
   assign status_o         = status_reg;
   assign option_o         = option_reg;
   assign direction_o      = dir_reg;
   assign reg_rdata_o      = rdata_reg;

endmodule
`default_nettype wire

// file: tb/rts_far_side.sv
`default_nettype none
// Oscillator source and slow RC tick beside the sequencer
module rts_far_side #(
   parameter int TICK_HALF = 101,
   parameter int OSC_HALF  = 79
) (
   // Free-running clocks, unrelated to the main clock
   output logic rc_tick_o,
   output logic osc_clk_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Both run well below half the main clock rate; one process drives each
   initial
   begin
      rc_tick_o = 1'b0;
      osc_clk_o = 1'b0;
      fork
         forever #(TICK_HALF) rc_tick_o = ~rc_tick_o;
         forever #(OSC_HALF) osc_clk_o = ~osc_clk_o;
      join
   end
endmodule
`default_nettype wire

// file: tb/rts_sequencer_properties.sv
`default_nettype none
// Temporal checks on the sequencer's ports
module rts_sequencer_properties
   import rts_pkg::*;
(
   // Clock and reset
   input wire logic            mclk_i,
   input wire logic            reset_n_i,
   // Causes
   input wire logic            power_rise_i,
   input wire logic            external_reset_n_i,
   input wire logic            watchdog_timeout_i,
   input wire logic            sleep_enter_i,
   // Results
   input wire logic            device_reset_n_o,
   input wire logic            core_stall_o,
   input wire logic            pc_load_o,
   input wire logic [PC_W-1:0] pc_load_value_o,
   input wire logic [7:0]      status_o,
   input wire logic [7:0]      option_o,
   input wire logic [7:0]      direction_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!reset_n_i);

   AST_RISE_HOLDS: assert property (power_rise_i |-> !device_reset_n_o)
      else $error("reset not held during power rise");
   AST_STALL_IN_RESET: assert property (!device_reset_n_o |-> core_stall_o)
      else $error("core runs while reset is held");
   AST_PC_AFTER_RESET: assert property ($rose(device_reset_n_o) |-> pc_load_o && pc_load_value_o == 13'h0000)
      else $error("no program counter load of zero after reset");
   AST_PC_PULSE: assert property (pc_load_o |=> !pc_load_o)
      else $error("program counter load longer than one cycle");
   AST_REGS_ON_RELEASE: assert property ($rose(device_reset_n_o) |-> option_o == 8'hff && direction_o == 8'hff)
      else $error("option or direction not all ones after reset");
   AST_BANK_CLEAR: assert property ($rose(device_reset_n_o) |-> status_o[7:5] == 3'b000)
      else $error("bank bits not cleared by reset");
   AST_PIN_RELEASE: assert property ($rose(device_reset_n_o) |-> $past(external_reset_n_i))
      else $error("reset released while the pin is low");
   AST_WDT_RESET: assert property (!core_stall_o && watchdog_timeout_i |=> !device_reset_n_o && status_o[4:3] == 2'b01)
      else $error("watchdog reset flags wrong");
   AST_SLEEP_FLAGS: assert property (!core_stall_o && sleep_enter_i && !watchdog_timeout_i
                                     |=> core_stall_o && status_o[4:3] == 2'b10)
      else $error("sleep entry flags wrong");
endmodule

bind rts_sequencer rts_sequencer_properties rts_sequencer_properties_i (
   .mclk_i             (mclk_i),
   .reset_n_i          (reset_n_i),
   .power_rise_i       (power_rise_i),
   .external_reset_n_i (external_reset_n_i),
   .watchdog_timeout_i (watchdog_timeout_i),
   .sleep_enter_i      (sleep_enter_i),
   .device_reset_n_o   (device_reset_n_o),
   .core_stall_o       (core_stall_o),
   .pc_load_o          (pc_load_o),
   .pc_load_value_o    (pc_load_value_o),
   .status_o           (status_o),
   .option_o           (option_o),
   .direction_o        (direction_o)
);
`default_nettype wire

// file: tb/test_rts_sequencer.sv
`default_nettype none
// Self-checking bench for the reset and time-out sequencer
module test_rts_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   import rts_pkg::*;

   localparam int TICK = 202;
   localparam int OSC  = 158;

   logic        mclk_i = 1'b0, reset_n_i = 1'b0, rise = 1'b0, dip = 1'b0, pin_n = 1'b1;
   logic        wdt = 1'b0, slp = 1'b0, irq = 1'b0, global_irq_enable = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [12:0] pc = 13'h0123;
   logic [7:0]  wdata = 8'h00;
   logic [2:0]  addr = 3'h0;
   logic        tick, osc, rst_n, stall, pcl;
   logic [12:0] pcv;
   logic [7:0]  st, opt, dir, rdata;
   int          err_count, checked, cyc;

   rts_sequencer #(.POWERUP_DELAY_TIMER_TICKS_P(8), .OST_CYCLES_P(16), .DIP_MIN_CYC_P(8), .EXT_FILTER_CYC_P(3)) rts_sequencer_i (
      .mclk_i(mclk_i), .reset_n_i(reset_n_i), .power_rise_i(rise), .supply_dip_i(dip),
      .external_reset_n_i(pin_n), .rc_tick_i(tick), .osc_clk_i(osc), .watchdog_timeout_i(wdt),
      .sleep_enter_i(slp), .irq_wake_i(irq), .global_irq_enable_i(global_irq_enable), .pc_i(pc),
      .device_reset_n_o(rst_n), .core_stall_o(stall), .pc_load_o(pcl), .pc_load_value_o(pcv),
      .status_o(st), .option_o(opt), .direction_o(dir), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));

   rts_far_side #(.TICK_HALF(TICK / 2), .OSC_HALF(OSC / 2)) rts_far_side_i (.rc_tick_o(tick), .osc_clk_o(osc));

   // Main clock and hang guard
   always #12.5 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic win(input int t, input int lo, input int hi);
      checked++;
      if (t < lo || t > hi)
      begin
         err_count++;
         $display("[ERR] %0t time %h outside %h to %h", $time, t, lo, hi);
      end
   endtask

   // Bus cycles end with an idle edge so strobes are never set twice at once
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
      @(posedge mclk_i);
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      @(posedge mclk_i);
      d = rdata;
   endtask

   // Waits for reset release or for the program counter load
   task automatic wait_on(input bit use_pcl, output int ns);
      int n;
      n = 0;
      while ((use_pcl ? pcl : rst_n) !== 1'b1 && n < 4000)
      begin
         @(posedge mclk_i);
         n++;
      end
      ns = n * 25;
   endtask

   task automatic test_cold();
      int t;
      logic [7:0] d;
      logic [7:0] exp [7] = '{8'h00, 8'h18, 8'hff, 8'hff, 8'h09, 8'h06, 8'h00};
      reset_n_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      wait_on(1'b0, t);
      win(t, 7 * TICK + 15 * OSC, 9 * TICK + 17 * OSC + 500);
      for (int a = 0; a < 7; a++)
      begin
         rd_reg(3'(a), d);
         cmp(16'(d), 16'(exp[a]));
      end
      $display("cold reset test done");
   endtask

   task automatic rise_run(input logic [7:0] cfg, input int nt, input int no);
      int t;
      logic [7:0] d;
      wr_reg(ADDR_CFG, cfg);
      wr_reg(ADDR_PRS, 8'h03);
      rise <= 1'b1;
      @(posedge mclk_i);
      rise <= 1'b0;
      wait_on(1'b0, t);
      win(t, (nt > 0 ? nt - 1 : 0) * TICK + (no > 0 ? no - 1 : 0) * OSC, (nt + 1) * TICK + (no + 1) * OSC + 500);
      cmp(16'(st & 8'hf8), 16'h18);
      rd_reg(ADDR_PRS, d);
      cmp(16'(d & 8'h02), 16'h00);
   endtask

   task automatic test_modes();
      logic [7:0] cfg [8] = '{8'h09, 8'h05, 8'h0d, 8'h04, 8'h06, 8'h03, 8'h07, 8'h09};
      for (int i = 0; i < 8; i++)
         rise_run(cfg[i], (!cfg[i][2] || cfg[i][3]) ? 8 : 0, (cfg[i][1:0] != 2'b11) ? 16 : 0);
      $display("mode table test done");
   endtask

   task automatic test_dip();
      int t;
      logic [7:0] d;
      wr_reg(ADDR_PRS, 8'h03);
      wr_reg(ADDR_STATUS, 8'hff);
      dip <= 1'b1;
      repeat (4) @(posedge mclk_i);
      dip <= 1'b0;
      repeat (20) @(posedge mclk_i);
      cmp(16'(rst_n), 16'h1);
      dip <= 1'b1;
      repeat (40) @(posedge mclk_i);
      cmp(16'(rst_n), 16'h0);
      dip <= 1'b0;
      repeat (5 * TICK / 25) @(posedge mclk_i);
      cmp(16'(rst_n), 16'h0);
      dip <= 1'b1;
      repeat (20) @(posedge mclk_i);
      dip <= 1'b0;
      wait_on(1'b0, t);
      win(t, 7 * TICK + 15 * OSC, 9 * TICK + 17 * OSC + 500);
      cmp(16'(st), 16'h1f);
      rd_reg(ADDR_PRS, d);
      cmp(16'(d), 16'h02);
      $display("supply dip test done");
   endtask

   task automatic test_wdt();
      int t;
      wr_reg(ADDR_OPTION, 8'h5a);
      wr_reg(ADDR_DIR, 8'ha5);
      wr_reg(ADDR_STATUS, 8'he0);
      wdt <= 1'b1;
      @(posedge mclk_i);
      wdt <= 1'b0;
      @(posedge mclk_i);
      cmp(16'(rst_n), 16'h0);
      wait_on(1'b0, t);
      cmp(16'(st), 16'h08);
      cmp({opt, dir}, 16'hffff);
      $display("watchdog reset test done");
   endtask

   // Watchdog wake, interrupt wake with and without the global enable
   task automatic test_sleep();
      int t;
      wr_reg(ADDR_OPTION, 8'h5a);
      for (int k = 0; k < 3; k++)
      begin
         slp <= 1'b1;
         @(posedge mclk_i);
         slp <= 1'b0;
         @(posedge mclk_i);
         cmp(16'(st[4:3]), 16'h2);
         global_irq_enable <= (k == 1);
         wdt <= (k == 0);
         irq <= (k != 0);
         @(posedge mclk_i);
         wdt <= 1'b0;
         irq <= 1'b0;
         wait_on(1'b1, t);
         win(t, 15 * OSC, 17 * OSC + 500);
         cmp(16'(pcv), (k == 1) ? 16'h0004 : 16'h0124);
         cmp(16'(st[4:3]), (k == 0) ? 16'h0 : 16'h2);
         cmp(16'(opt), 16'h5a);
      end
      // Pin reset while asleep: flags 1,0, registers and program counter reset
      slp <= 1'b1;
      @(posedge mclk_i);
      slp <= 1'b0;
      pin_n <= 1'b0;
      repeat (10) @(posedge mclk_i);
      pin_n <= 1'b1;
      wait_on(1'b1, t);
      cmp(16'({st[4:3], opt}), 16'h02ff);
      cmp(16'(pcv), 16'h0000);
      $display("sleep wake test done");
   endtask

   task automatic test_pin();
      int t;
      pin_n <= 1'b0;
      repeat (2) @(posedge mclk_i);
      pin_n <= 1'b1;
      repeat (10) @(posedge mclk_i);
      cmp(16'({rst_n, stall}), 16'h2);
      pin_n <= 1'b0;
      rise <= 1'b1;
      @(posedge mclk_i);
      rise <= 1'b0;
      repeat (220) @(posedge mclk_i);
      cmp(16'(rst_n), 16'h0);
      pin_n <= 1'b1;
      wait_on(1'b0, t);
      win(t, 0, 250);
      $display("pin reset test done");
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Main sequence, with a second cold reset at the end
   initial
   begin
      @(posedge mclk_i);
      test_cold();
      test_modes();
      test_dip();
      test_wdt();
      test_sleep();
      test_pin();
      test_cold();
      report_and_stop();
   end
endmodule
`default_nettype wire
